// ==== hw/dcpc_pkg.sv ====
// Shared constants and types for the dual clock power control block
package dcpc_pkg;

	// ----------------------------------------
	// Clock mode register layout
	// ----------------------------------------
	localparam int CMR_W = 8;
	localparam logic [7:0] CMR_RESET = 8'h03;
	localparam int CMR_SLOW_LSB = 5;
	localparam int CMR_SLOW_W = 3;
	localparam int CMR_HLSEL_BIT = 0;

	// ----------------------------------------
	// RTC control register layout
	// ----------------------------------------
	localparam logic [7:0] RTCR_RESET = 8'h00;
	localparam int RTCR_QUICK_BIT = 4;

	// ----------------------------------------
	// Rates and dividers
	// ----------------------------------------
	localparam int MCLK_HZ = 50000000;
	localparam int RTC_HZ = 32768;
	localparam int LCD_DIV = 8;
	localparam int AUX_SYS_DIV = 4;
	localparam int SLOW_DIV_MIN = 2;
	localparam int SLOW_DIV_MAX = 64;
	localparam int QUICK_HINT_S = 2;
	localparam int DIV_W = 7;

	// Operating states
	typedef enum logic [2:0] {
		DCPC_NORMAL = 3'b000,
		DCPC_SLOW0 = 3'b001,
		DCPC_SLOW1 = 3'b010,
		DCPC_IDLE = 3'b011,
		DCPC_SLEEP = 3'b100
	} dcpc_mode_type;

	// Slow divider ratio: 2,4,...,64 from a 3-bit select, clamped at the top
	function automatic logic [DIV_W-1:0] dcpc_slow_ratio(input logic [2:0] sel);
		logic [DIV_W-1:0] r;
		r = 7'h02 << sel;
		if (sel > 3'h5) begin
			r = 7'h40;
		end
		return r;
	endfunction : dcpc_slow_ratio

endpackage : dcpc_pkg

// ==== hw/dcpc_edge_div.sv ====
// Enable-pulse divider: one output pulse per ratio input pulses
`timescale 1ns/10ps
`default_nettype none
module dcpc_edge_div
	import dcpc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic en_i,
	input wire logic [DIV_W-1:0] ratio_i,
	output logic tick_o
);
	logic [DIV_W-1:0] cnt_r;

	// Counter restarts on reset so ratio changes take effect cleanly
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_r <= 7'h00;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (en_i) begin
				if (cnt_r >= ratio_i - 7'h01) begin
					cnt_r <= 7'h00;
					tick_o <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 7'h01;
				end
			end
		end
	end
endmodule : dcpc_edge_div
`default_nettype wire

// ==== hw/dcpc_sync.sv ====
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module dcpc_sync (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;

	// First stage feeds only the second
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			meta_r <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : dcpc_sync
`default_nettype wire

// ==== hw/dcpc_top.sv ====
// Clock enable generation and power mode sequencing
//
// What this block does
// - Power-down stops system clock; internal RC sub-clock runs in idle, in sleep only with cfg_sub_in_sleep_i
// - RTC oscillator ticks in every state
// - Configuration picks sub-clock source RTC or RC
// - Quick-start bit resets to zero
// - RTC clock unaffected by quick-start bit
// - External clock from pin; filter bypass option
// - Configuration picks crystal or RC main source
// - Slow divider select sets slow clock rate
// - LCD clock is sub-clock divided by eight
// - Auxiliary clock from sub-clock or system/4
// - Normal mode: system equals main clock
// - Slow mode 0: main stopped, sub-oscillator slow
// - Slow mode 1: main divided 2 to 64
// - Idle: CPU off, aux only from sub-clock
// - Sleep: all stop; sub and watchdog configurable
// - Stop instruction alone enters power-down; hold
// - State and registers retained across power-down
// - Watchdog cleared; runs on own oscillator, or in idle on aux when aux is from sub-clock
// - Power-down sets flag, clears time-out flag
// - High/low select picks system clock source
//
// All clocks are modelled as one-cycle enables on mclk_i.
// A pin must hold each level for two mclk_i cycles, or its edge may be lost.
`timescale 1ns/10ps
`default_nettype none
module dcpc_top
	import dcpc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	// Oscillator pins, already squared up
	input wire logic main_osc_input_i,
	input wire logic main_osc_rc_i,
	input wire logic rtc_crystal_in_i,
	input wire logic internal_rc_sub_osc_i,
	// Configuration options
	input wire logic cfg_main_ext_clk_i,
	input wire logic cfg_main_rc_i,
	input wire logic cfg_filter_bypass_i,
	input wire logic cfg_sub_rtc_i,
	input wire logic cfg_aux_from_sub_i,
	input wire logic cfg_wdt_own_osc_i,
	input wire logic cfg_wdt_enable_i,
	input wire logic cfg_sub_in_sleep_i,
	// Register writes from the core
	input wire logic cmr_we_i,
	input wire logic [7:0] cmr_wdata_i,
	input wire logic rtcr_we_i,
	input wire logic [7:0] rtcr_wdata_i,
	input wire logic lcd_clock_enable_i,
	input wire logic wdt_ctrl_enable_i,
	// Core events
	input wire logic stop_exec_i,
	input wire logic idle_req_i,
	input wire logic wake_i,
	input wire logic wdt_clear_i,
	input wire logic wdt_timeout_i,
	// Clock enables and status
	output logic main_clock_o,
	output logic sub_clock_o,
	output logic slow_clock_o,
	output logic system_clock_o,
	output logic auxiliary_clock_o,
	output logic lcd_clock_o,
	output logic watchdog_clock_o,
	output logic cpu_run_o,
	output logic main_osc_run_o,
	output logic main_osc_output_o,
	output logic hold_pc_o,
	output logic wdt_clear_o,
	output logic powerdown_flag_o,
	output logic watchdog_timeout_flag_o,
	output logic [7:0] clock_mode_reg_o,
	output logic [7:0] rtc_control_reg_o,
	output logic [2:0] mode_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic xtal_s, rcm_s, rtc_s, irc_s;
	dcpc_sync u_sx (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(main_osc_input_i), .q_o(xtal_s));
	dcpc_sync u_sr (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(main_osc_rc_i), .q_o(rcm_s));
	dcpc_sync u_st (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(rtc_crystal_in_i), .q_o(rtc_s));
	dcpc_sync u_si (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(internal_rc_sub_osc_i), .q_o(irc_s));

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] cmr_r;
	logic [7:0] rtcr_r;
	dcpc_mode_type mode_r, mode_nxt;
	logic pdf_r, to_r;

	// Clock mode register; power-down leaves it untouched
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cmr_r <= CMR_RESET;
		end else if (cmr_we_i && cpu_run_o) begin
			cmr_r <= cmr_wdata_i;
		end
	end

	// RTC control register; quick-start only affects power, not the clock
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rtcr_r <= RTCR_RESET;
		end else if (rtcr_we_i && cpu_run_o) begin
			rtcr_r <= rtcr_wdata_i;
		end
	end

	// Fields of the two control registers
	logic hl_sel, quick_n;
	logic [2:0] slow_sel;
	assign hl_sel = cmr_r[CMR_HLSEL_BIT];
	assign slow_sel = cmr_r[CMR_SLOW_LSB +: CMR_SLOW_W];
	assign quick_n = rtcr_r[RTCR_QUICK_BIT];

	// ----------------------------------------
	// Source edge detection
	// ----------------------------------------
	logic main_lvl, main_d_r, sub_lvl, sub_d_r, filt_r;
	// Filter needs two high samples to pass a high, a single low sample passes a low; bypass with the external clock uses the raw synchronised level
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			filt_r <= 1'b0;
		end else begin
			filt_r <= cfg_main_ext_clk_i ? xtal_s : (cfg_main_rc_i ? rcm_s : xtal_s);
		end
	end

	logic main_raw;
	assign main_raw = cfg_main_ext_clk_i ? xtal_s : (cfg_main_rc_i ? rcm_s : xtal_s);
	assign main_lvl = (cfg_main_ext_clk_i && cfg_filter_bypass_i) ? main_raw : (main_raw & filt_r);
	assign sub_lvl = cfg_sub_rtc_i ? rtc_s : irc_s;

	logic main_run;
	// Main oscillator stops in slow mode 0, idle and sleep
	assign main_run = (mode_r == DCPC_NORMAL) || (mode_r == DCPC_SLOW1);

	// Previous levels for rising-edge detection
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			main_d_r <= 1'b0;
			sub_d_r <= 1'b0;
		end else begin
			main_d_r <= main_lvl;
			sub_d_r <= sub_lvl;
		end
	end

	logic main_tick, sub_tick, sub_run;
	// Sub-clock keeps running in power-down unless sleep config stops it
	assign sub_run = (mode_r != DCPC_SLEEP) || cfg_sub_in_sleep_i || cfg_sub_rtc_i;
	assign main_tick = main_run && main_lvl && !main_d_r;
	assign sub_tick = sub_run && sub_lvl && !sub_d_r;

	// ----------------------------------------
	// Dividers
	// ----------------------------------------
	logic slow1_tick, lcd_tick, sys4_tick, sys_tick;
	logic [DIV_W-1:0] ratio_slow;
	assign ratio_slow = dcpc_slow_ratio(slow_sel);
	// Restart of the slow divider; driven in the mode section below
	logic slow1_restart;

	// Main divided for slow mode 1
	dcpc_edge_div u_slow (
		.mclk_i(mclk_i),
		.reset_i(slow1_restart),
		.en_i(main_tick),
		.ratio_i(ratio_slow),
		.tick_o(slow1_tick)
	);

	// LCD clock from sub-clock
	dcpc_edge_div u_lcd (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.en_i(sub_tick),
		.ratio_i(7'(LCD_DIV)),
		.tick_o(lcd_tick)
	);

	// System clock divided by four for the auxiliary path
	dcpc_edge_div u_sys4 (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.en_i(sys_tick),
		.ratio_i(7'(AUX_SYS_DIV)),
		.tick_o(sys4_tick)
	);

	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	// Stop instruction is the only path into power-down; wake returns to the run mode
	dcpc_mode_type run_mode;
	// Low select with the top divider code means slow mode 0
	always_comb begin
		if (!hl_sel) begin
			run_mode = (slow_sel == 3'h7) ? DCPC_SLOW0 : DCPC_SLOW1;
		end else begin
			run_mode = DCPC_NORMAL;
		end
	end

	// Next mode; power-down is reached only from a run mode
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			DCPC_NORMAL, DCPC_SLOW0, DCPC_SLOW1: begin
				if (stop_exec_i) begin
					mode_nxt = idle_req_i ? DCPC_IDLE : DCPC_SLEEP;
				end else begin
					mode_nxt = run_mode;
				end
			end
			DCPC_IDLE, DCPC_SLEEP: begin
				if (wake_i) begin
					mode_nxt = run_mode;
				end
			end
			default: mode_nxt = DCPC_NORMAL;
		endcase
	end

	// Mode changes on a system clock boundary, on a stop instruction, or at once out of idle and sleep, to avoid runt pulses
	logic switch_ok;
	assign switch_ok = sys_tick || (mode_r == DCPC_IDLE) || (mode_r == DCPC_SLEEP) || stop_exec_i;

	// Entering slow mode 1 restarts its divider on the switching edge, so the
	// first slow period is a whole one rather than a leftover of the old count
	logic slow1_entry;
	assign slow1_entry = switch_ok && (mode_nxt == DCPC_SLOW1) && (mode_r != DCPC_SLOW1);
	assign slow1_restart = reset_i || slow1_entry;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			mode_r <= DCPC_NORMAL;
		end else if (switch_ok) begin
			mode_r <= mode_nxt;
		end
	end

	// ----------------------------------------
	// System clock selection
	// ----------------------------------------
	// Sys tick comes from exactly one source; a whole pulse or none, never a part
	always_comb begin
		unique case (mode_r)
			DCPC_NORMAL: sys_tick = main_tick;
			DCPC_SLOW0: sys_tick = sub_tick;
			DCPC_SLOW1: sys_tick = slow1_tick;
			default: sys_tick = 1'b0;
		endcase
	end

	logic slow_tick;
	assign slow_tick = (mode_r == DCPC_SLOW0) ? sub_tick : ((mode_r == DCPC_IDLE || mode_r == DCPC_SLEEP) ? 1'b0 : slow1_tick);

	logic aux_tick, aux_run, lcd_run, wdt_src, wdt_run;
	// Aux from system/4 dies with the system clock; sleep stops it outright
	assign aux_run = (mode_r != DCPC_SLEEP);
	assign aux_tick = aux_run && (cfg_aux_from_sub_i ? sub_tick : sys4_tick);
	assign lcd_run = lcd_clock_enable_i && (mode_r != DCPC_SLEEP);
	assign wdt_run = cfg_wdt_enable_i && wdt_ctrl_enable_i;
	// Watchdog on its own oscillator counts sub-clock ticks; otherwise it follows the aux clock
	assign wdt_src = cfg_wdt_own_osc_i ? sub_tick : aux_tick;

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			main_clock_o <= 1'b0;
			sub_clock_o <= 1'b0;
			slow_clock_o <= 1'b0;
			system_clock_o <= 1'b0;
			auxiliary_clock_o <= 1'b0;
			lcd_clock_o <= 1'b0;
			watchdog_clock_o <= 1'b0;
		end else begin
			main_clock_o <= main_tick;
			sub_clock_o <= sub_tick;
			slow_clock_o <= slow_tick;
			system_clock_o <= sys_tick;
			auxiliary_clock_o <= aux_tick;
			lcd_clock_o <= lcd_tick && lcd_run;
			watchdog_clock_o <= wdt_src && wdt_run;
		end
	end

	// Status and control outputs
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cpu_run_o <= 1'b1;
			main_osc_run_o <= 1'b1;
			main_osc_output_o <= 1'b0;
			hold_pc_o <= 1'b0;
			clock_mode_reg_o <= CMR_RESET;
			rtc_control_reg_o <= RTCR_RESET;
			mode_o <= DCPC_NORMAL;
		end else begin
			cpu_run_o <= !(mode_nxt == DCPC_IDLE || mode_nxt == DCPC_SLEEP) && !stop_exec_i;
			main_osc_run_o <= main_run && !stop_exec_i;
			main_osc_output_o <= main_lvl && main_run && !cfg_main_ext_clk_i;
			hold_pc_o <= (mode_nxt == DCPC_IDLE || mode_nxt == DCPC_SLEEP);
			clock_mode_reg_o <= cmr_r;
			rtc_control_reg_o <= {rtcr_r[7:5], quick_n, rtcr_r[3:0]};
			mode_o <= mode_r;
		end
	end

	// Power-down and time-out flags; entry wins over other updates
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pdf_r <= 1'b0;
			to_r <= 1'b0;
			wdt_clear_o <= 1'b0;
		end else begin
			wdt_clear_o <= stop_exec_i || wdt_clear_i;
			if (stop_exec_i && cpu_run_o) begin
				pdf_r <= 1'b1;
				to_r <= 1'b0;
			end else if (wdt_timeout_i) begin
				to_r <= 1'b1;
			end else if (wdt_clear_i) begin
				pdf_r <= 1'b0;
				to_r <= 1'b0;
			end
		end
	end

	assign powerdown_flag_o = pdf_r;
	assign watchdog_timeout_flag_o = to_r;

endmodule : dcpc_top
`default_nettype wire

// ==== tb/dcpc_checker.sv ====
// Port-level assertions for the dual clock power control block
`timescale 1ns/10ps
`default_nettype none
module dcpc_checker
	import dcpc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic stop_exec_i,
	input wire logic idle_req_i,
	input wire logic cmr_we_i,
	input wire logic [7:0] cmr_wdata_i,
	input wire logic rtcr_we_i,
	input wire logic [7:0] rtcr_wdata_i,
	input wire logic lcd_clock_enable_i,
	input wire logic cfg_aux_from_sub_i,
	input wire logic cpu_run_o,
	input wire logic hold_pc_o,
	input wire logic wdt_clear_o,
	input wire logic powerdown_flag_o,
	input wire logic watchdog_timeout_flag_o,
	input wire logic [7:0] clock_mode_reg_o,
	input wire logic [7:0] rtc_control_reg_o,
	input wire logic [2:0] mode_o,
	input wire logic main_clock_o,
	input wire logic slow_clock_o,
	input wire logic system_clock_o,
	input wire logic auxiliary_clock_o,
	input wire logic lcd_clock_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// Halt is only taken while the core runs
	wire logic halt_go = stop_exec_i && cpu_run_o;
	wire logic idle_m = mode_o == DCPC_IDLE;
	wire logic sleep_m = mode_o == DCPC_SLEEP;
	property p_halt_flags; halt_go |=> powerdown_flag_o && !watchdog_timeout_flag_o; endproperty
	property p_halt_core; halt_go |=> !cpu_run_o && hold_pc_o; endproperty
	property p_wdt_clr; halt_go |=> wdt_clear_o; endproperty
	property p_to_idle; halt_go && idle_req_i |-> ##2 idle_m; endproperty
	property p_to_sleep; halt_go && !idle_req_i |-> ##2 sleep_m; endproperty
	// Register outputs trail the write by two edges: the register, then its output copy
	property p_cmr_wr; cmr_we_i && cpu_run_o |-> ##2 clock_mode_reg_o[7:5] == $past(cmr_wdata_i[7:5], 2)
		&& clock_mode_reg_o[0] == $past(cmr_wdata_i[0], 2); endproperty
	property p_rtcr_wr; rtcr_we_i && cpu_run_o |-> ##2 rtc_control_reg_o[4] == $past(rtcr_wdata_i[4], 2);
		endproperty
	// Halted writes change nothing; a write taken beside the stop lands one edge later
	property p_frozen; !cpu_run_o && !$past(cpu_run_o) |=> $stable(clock_mode_reg_o) && $stable(rtc_control_reg_o);
		endproperty
	property p_halt_quiet; (idle_m || sleep_m) && $past(idle_m || sleep_m)
		|-> !system_clock_o && !main_clock_o && !slow_clock_o; endproperty
	property p_sleep_off; sleep_m && $past(sleep_m) |-> !auxiliary_clock_o && !lcd_clock_o; endproperty
	property p_idle_aux; idle_m && $past(idle_m) && !cfg_aux_from_sub_i |-> !auxiliary_clock_o; endproperty
	property p_lcd_gate; (!lcd_clock_enable_i)[*4] |-> !lcd_clock_o; endproperty
	property p_lcd_gap; lcd_clock_o |=> (!lcd_clock_o)[*7]; endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("flags wrong after halt");
	a_halt_core: assert property (p_halt_core) else $error("core not held after halt");
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared on halt");
	a_to_idle: assert property (p_to_idle) else $error("idle mode not entered");
	a_to_sleep: assert property (p_to_sleep) else $error("sleep mode not entered");
	a_cmr_wr: assert property (p_cmr_wr) else $error("clock mode write lost");
	a_rtcr_wr: assert property (p_rtcr_wr) else $error("quick start write lost");
	a_frozen: assert property (p_frozen) else $error("register changed while halted");
	a_halt_quiet: assert property (p_halt_quiet) else $error("core clocks run while halted");
	a_sleep_off: assert property (p_sleep_off) else $error("aux or lcd clock in sleep");
	a_idle_aux: assert property (p_idle_aux) else $error("aux clock from system in idle");
	a_lcd_gate: assert property (p_lcd_gate) else $error("lcd clock while disabled");
	a_lcd_gap: assert property (p_lcd_gap) else $error("lcd pulses too close");
	c_idle: cover property (halt_go && idle_req_i);
	c_sleep: cover property (halt_go && !idle_req_i);
	c_cmr: cover property (cmr_we_i && cpu_run_o);
	c_lcd: cover property (lcd_clock_o);
endmodule : dcpc_checker
bind dcpc_top dcpc_checker i_dcpc_checker (.*);
`default_nettype wire

// ==== tb/dcpc_top_test.sv ====
// Self-checking bench for the dual clock power control block
`timescale 1ns/10ps
`default_nettype none
module dcpc_top_test import dcpc_pkg::*; ();
	logic mclk_i = 0, reset_i = 1, main_osc_input_i = 0, main_osc_rc_i = 0, rtc_crystal_in_i = 0;
	logic internal_rc_sub_osc_i = 0, cfg_main_ext_clk_i = 0, cfg_main_rc_i = 0, cfg_filter_bypass_i = 0;
	logic cfg_sub_rtc_i = 1, cfg_aux_from_sub_i = 0, cfg_wdt_own_osc_i = 1, cfg_wdt_enable_i = 1;
	logic cfg_sub_in_sleep_i = 1, cmr_we_i = 0, rtcr_we_i = 0, lcd_clock_enable_i = 1, wdt_ctrl_enable_i = 1;
	logic stop_exec_i = 0, idle_req_i = 0, wake_i = 0, wdt_clear_i = 0, wdt_timeout_i = 0;
	logic [7:0] cmr_wdata_i = 8'h00, rtcr_wdata_i = 8'h00;
	logic main_clock_o, sub_clock_o, slow_clock_o, system_clock_o, auxiliary_clock_o, lcd_clock_o;
	logic watchdog_clock_o, cpu_run_o, main_osc_run_o, main_osc_output_o, hold_pc_o, wdt_clear_o;
	logic powerdown_flag_o, watchdog_timeout_flag_o;
	logic [7:0] clock_mode_reg_o, rtc_control_reg_o;
	logic [2:0] mode_o;
	int bad_count = 0, n_compared = 0, r, e;
	// Four-state counters, so an unknown pulse spoils the count instead of reading as zero
	integer cm, cs, cu, ca, cl, cw, co;
	typedef struct {logic [7:0] cmr; logic [2:0] mode; int ratio;} dcpc_row_type;
	// Ratio 0 marks the sub-clock mode, 1 the full main rate
	dcpc_row_type rows [7] = '{'{8'h03, DCPC_NORMAL, 1}, '{8'h00, DCPC_SLOW1, 2}, '{8'h20, DCPC_SLOW1, 4},
		'{8'hA0, DCPC_SLOW1, 64}, '{8'hC0, DCPC_SLOW1, 64}, '{8'hE0, DCPC_SLOW0, 0}, '{8'h01, DCPC_NORMAL, 1}};

	dcpc_top i_dcpc_top (.*);

	// Clock and oscillator pins; pin periods are 8, 13, 31 and 73 mclk_i periods
	always #10 mclk_i = ~mclk_i;
	always #80 main_osc_input_i = ~main_osc_input_i;
	always #130 main_osc_rc_i = ~main_osc_rc_i;
	always #310 rtc_crystal_in_i = ~rtc_crystal_in_i;
	always #730 internal_rc_sub_osc_i = ~internal_rc_sub_osc_i;

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	// Range compare; an unknown never lands inside the range
	task automatic cmp(input string nm, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
		n_compared++;
		if ((got < lo) !== 1'h0 || (got > hi) !== 1'h0) begin
			bad_count++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : cmp

	// Counts enable pulses at falling edges, where they are settled
	task automatic count(input int n);
		{cm, cs, cu, ca, cl, cw, co} = '0;
		repeat (n) begin
			@(negedge mclk_i);
			cm += main_clock_o;
			cs += system_clock_o;
			cu += sub_clock_o;
			ca += auxiliary_clock_o;
			cl += lcd_clock_o;
			cw += watchdog_clock_o;
			co += main_osc_output_o;
		end
	endtask : count

	task automatic wr(input logic rtc, input logic [7:0] d);
		cmr_we_i = !rtc;
		rtcr_we_i = rtc;
		cmr_wdata_i = d;
		rtcr_wdata_i = d;
		@(negedge mclk_i);
		cmr_we_i = 0;
		rtcr_we_i = 0;
	endtask : wr

	// Mode moves on a system tick, so the wait spans two slowest ticks
	task automatic await(input logic [2:0] m);
		for (int i = 0; i < 1200 && mode_o !== m; i++) @(negedge mclk_i);
		cmp("mode", m, m, mode_o);
		if (mode_o !== m) end_of_test();
	endtask : await

	task automatic halt(input logic idle, input logic [2:0] m);
		idle_req_i = idle;
		stop_exec_i = 1;
		@(negedge mclk_i);
		stop_exec_i = 0;
		cmp("pdf", 1, 1, powerdown_flag_o);
		cmp("to", 0, 0, watchdog_timeout_flag_o);
		cmp("run", 0, 0, cpu_run_o);
		cmp("hold", 1, 1, hold_pc_o);
		cmp("wdt clr", 1, 1, wdt_clear_o);
		cmp("osc run", 0, 0, main_osc_run_o);
		@(negedge mclk_i);
		cmp("halt mode", m, m, mode_o);
		wr(0, 8'h41);
		count(2000);
		cmp("sys", 0, 0, cs);
		cmp("main", 0, 0, cm);
		cmp("cmr kept", 8'h01, 8'h01, clock_mode_reg_o);
	endtask : halt

	task automatic wake();
		wake_i = 1;
		@(negedge mclk_i);
		wake_i = 0;
		await(DCPC_NORMAL);
		count(2);
		cmp("run", 1, 1, cpu_run_o);
		cmp("osc run", 1, 1, main_osc_run_o);
	endtask : wake

	initial begin
		repeat (3) @(negedge mclk_i);
		reset_i = 0;
		cmp("cmr", CMR_RESET, CMR_RESET, clock_mode_reg_o);
		cmp("quick", 0, 0, rtc_control_reg_o[RTCR_QUICK_BIT]);
		cmp("pdf", 0, 0, powerdown_flag_o);
		$display("test reset done");
		wr(1, 8'h10);
		@(negedge mclk_i);
		cmp("quick", 1, 1, rtc_control_reg_o[RTCR_QUICK_BIT]);
		for (int s = 0; s < 2; s++) begin
			cfg_sub_rtc_i = s[0];
			count(2000);
			e = s ? 64 : 27;
			cmp("sub", e - 2, e + 2, cu);
			cmp("lcd", cu / 8 - 1, cu / 8 + 1, cl);
		end
		lcd_clock_enable_i = 0;
		count(2000);
		cmp("lcd off", 0, 0, cl);
		lcd_clock_enable_i = 1;
		$display("test sub clock done");
		foreach (rows[i]) begin
			wr(0, rows[i].cmr);
			await(rows[i].mode);
			count(2000);
			r = rows[i].ratio;
			if (r == 0) begin
				cmp("main off", 0, 0, cm);
				cmp("slow0 sys", cu - 1, cu + 1, cs);
			end else begin
				cmp("main", 248, 252, cm);
				cmp("sys", cm / r - 1, cm / r + 1, cs);
			end
			if (r == 1) cmp("aux", cs / 4 - 1, cs / 4 + 1, ca);
		end
		cfg_main_rc_i = 1;
		count(2000);
		cmp("rc main", 150, 156, cm);
		cmp("osc out", 1, 2000, co);
		cfg_main_rc_i = 0;
		cfg_main_ext_clk_i = 1;
		cfg_filter_bypass_i = 1;
		count(2000);
		cmp("ext main", 248, 252, cm);
		cmp("ext osc out", 0, 0, co);
		cfg_main_ext_clk_i = 0;
		cfg_filter_bypass_i = 0;
		$display("test modes done");
		cfg_aux_from_sub_i = 1;
		halt(1, DCPC_IDLE);
		cmp("sub", 60, 68, cu);
		cmp("aux", cu - 1, cu + 1, ca);
		cmp("wdt", cu - 1, cu + 1, cw);
		wake();
		cfg_aux_from_sub_i = 0;
		cfg_wdt_own_osc_i = 0;
		halt(1, DCPC_IDLE);
		cmp("aux sys", 0, 0, ca);
		cmp("wdt sys", 0, 0, cw);
		wake();
		$display("test idle done");
		wdt_timeout_i = 1;
		count(2);
		wdt_timeout_i = 0;
		cmp("to", 1, 1, watchdog_timeout_flag_o);
		wdt_clear_i = 1;
		count(1);
		wdt_clear_i = 0;
		cmp("to clr", 0, 0, watchdog_timeout_flag_o);
		cfg_sub_rtc_i = 0;
		cfg_sub_in_sleep_i = 0;
		halt(0, DCPC_SLEEP);
		cmp("aux", 0, 0, ca);
		cmp("lcd", 0, 0, cl);
		cmp("sub", 0, 0, cu);
		wake();
		$display("test sleep done");
		reset_i = 1;
		repeat (3) @(negedge mclk_i);
		reset_i = 0;
		cmp("cmr", CMR_RESET, CMR_RESET, clock_mode_reg_o);
		cmp("quick", 0, 0, rtc_control_reg_o[RTCR_QUICK_BIT]);
		cmp("pdf", 0, 0, powerdown_flag_o);
		cmp("mode", DCPC_NORMAL, DCPC_NORMAL, mode_o);
		$display("test mid reset done");
		end_of_test();
	end
endmodule : dcpc_top_test
`default_nettype wire
